// ==== bbf_consts.svh ====
`ifndef BBF_CONSTS_SVH
`define BBF_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define BBF_OFF_CMD    8'h00
`define BBF_OFF_FLAGS  8'h04
`define BBF_OFF_PC     8'h08
`define BBF_OFF_OPND   8'h0c
`define BBF_OFF_IO     8'h10
`define BBF_OFF_STAT   8'h14

// Command word fields.
`define BBF_CMD_OP_LO   0
`define BBF_CMD_BIT_LO  8
`define BBF_CMD_OFS_LO  16

// Status flag positions.
`define BBF_FLAG_C  0
`define BBF_FLAG_Z  1
`define BBF_FLAG_N  2
`define BBF_FLAG_V  3
`define BBF_FLAG_S  4
`define BBF_FLAG_H  5
`define BBF_FLAG_T  6
`define BBF_FLAG_I  7

// Status word bit positions.
`define BBF_STAT_BUSY   0
`define BBF_STAT_TAKEN  1

// Reset values.
`define BBF_RST_FLAGS  8'h00
`define BBF_RST_PC     16'h0000
`define BBF_RST_BYTE   8'h00
`define BBF_RST_CMD    32'h0000_0000

// Cycle counts of the operations.
`define BBF_CYC_SHORT  1
`define BBF_CYC_LONG   2

// AXI responses.
`define BBF_RESP_OKAY    2'h0
`define BBF_RESP_SLVERR  2'h2

`endif

// ==== bbf_pkg.sv ====
`default_nettype none

package bbf_pkg;

	// Operation codes; values below 6'h10 are the conditional branches.
	typedef enum logic [5:0] {
		branch_carry_clear      = 6'h00,
		branch_same_or_higher   = 6'h01,
		branch_lower            = 6'h02,
		branch_minus            = 6'h03,
		branch_plus             = 6'h04,
		branch_signed_ge        = 6'h05,
		branch_signed_lt        = 6'h06,
		branch_half_carry_set   = 6'h07,
		branch_half_carry_clear = 6'h08,
		branch_transfer_set     = 6'h09,
		branch_transfer_clear   = 6'h0a,
		branch_overflow_set     = 6'h0b,
		branch_overflow_clear   = 6'h0c,
		branch_irq_enabled      = 6'h0d,
		branch_irq_disabled     = 6'h0e,
		io_bit_set              = 6'h10,
		io_bit_clear            = 6'h11,
		shift_left_logical      = 6'h12,
		shift_right_logical     = 6'h13,
		rotate_left_carry       = 6'h14,
		rotate_right_carry      = 6'h15,
		shift_right_arith       = 6'h16,
		nibble_swap             = 6'h17,
		flag_set_indexed        = 6'h18,
		flag_clear_indexed      = 6'h19,
		bit_to_transfer_flag    = 6'h1a,
		transfer_flag_to_bit    = 6'h1b,
		global_irq_on           = 6'h1c,
		global_irq_off          = 6'h1d,
		signed_flag_on          = 6'h1e,
		signed_flag_off         = 6'h1f,
		overflow_flag_on        = 6'h20,
		overflow_flag_off       = 6'h21,
		half_carry_on           = 6'h22,
		half_carry_off          = 6'h23
	} bbf_op_t;

	// Sequencer states, Gray coded along idle, execute, finish.
	typedef enum logic [1:0] {
		st_idle   = 2'h0,
		st_exec   = 2'h1,
		st_finish = 2'h3
	} bbf_state_t;

endpackage

`default_nettype wire

// ==== bbf_unit.sv ====
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "bbf_consts.svh"

module bbf_unit (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             busy
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// True when a word address selects the given register.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr[7:2] == off[7:2]);
	endfunction

	// True for any mapped register.
	function automatic logic mapped(input logic [7:0] addr);
		mapped = hit(addr, `BBF_OFF_CMD) | hit(addr, `BBF_OFF_FLAGS) | hit(addr, `BBF_OFF_PC) |
			hit(addr, `BBF_OFF_OPND) | hit(addr, `BBF_OFF_IO) | hit(addr, `BBF_OFF_STAT);
	endfunction

	// Merges written bytes into an old word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction

	// True for the conditional branch codes.
	function automatic logic is_branch(input bbf_pkg::bbf_op_t op);
		is_branch = (op[5:4] == 2'h0);
	endfunction

	// Branch condition against the status flags.
	function automatic logic br_cond(input bbf_pkg::bbf_op_t op, input logic [7:0] f);
		case (op)
			bbf_pkg::branch_carry_clear, bbf_pkg::branch_same_or_higher: br_cond = ~f[`BBF_FLAG_C];
			bbf_pkg::branch_lower:            br_cond = f[`BBF_FLAG_C];
			bbf_pkg::branch_minus:            br_cond = f[`BBF_FLAG_N];
			bbf_pkg::branch_plus:             br_cond = ~f[`BBF_FLAG_N];
			bbf_pkg::branch_signed_ge:        br_cond = ~(f[`BBF_FLAG_N] ^ f[`BBF_FLAG_V]);
			bbf_pkg::branch_signed_lt:        br_cond = f[`BBF_FLAG_N] ^ f[`BBF_FLAG_V];
			bbf_pkg::branch_half_carry_set:   br_cond = f[`BBF_FLAG_H];
			bbf_pkg::branch_half_carry_clear: br_cond = ~f[`BBF_FLAG_H];
			bbf_pkg::branch_transfer_set:     br_cond = f[`BBF_FLAG_T];
			bbf_pkg::branch_transfer_clear:   br_cond = ~f[`BBF_FLAG_T];
			bbf_pkg::branch_overflow_set:     br_cond = f[`BBF_FLAG_V];
			bbf_pkg::branch_overflow_clear:   br_cond = ~f[`BBF_FLAG_V];
			bbf_pkg::branch_irq_enabled:      br_cond = f[`BBF_FLAG_I];
			bbf_pkg::branch_irq_disabled:     br_cond = ~f[`BBF_FLAG_I];
			default:                          br_cond = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State.

	bbf_pkg::bbf_state_t state_r;
	bbf_pkg::bbf_state_t state_nxt;
	logic [31:0]         cmd_r;
	logic [7:0]          flags_r;
	logic [7:0]          flags_nxt;
	logic [15:0]         pc_r;
	logic [15:0]         pc_nxt;
	logic [7:0]          opnd_r;
	logic [7:0]          opnd_nxt;
	logic [7:0]          io_r;
	logic [7:0]          io_nxt;
	logic                taken_r;
	logic                aw_have_r;
	logic                w_have_r;
	logic [7:0]          awaddr_r;
	logic [31:0]         wdata_r;
	logic [3:0]          wstrb_r;
	logic                wr_fire;
	logic                sw_wr;
	bbf_pkg::bbf_op_t    op;
	logic [2:0]          bsel;
	logic [7:0]          ofs;
	logic [7:0]          mask;
	logic [15:0]         target;

	assign op     = bbf_pkg::bbf_op_t'(cmd_r[`BBF_CMD_OP_LO +: 6]);
	assign bsel   = cmd_r[`BBF_CMD_BIT_LO +: 3];
	assign ofs    = cmd_r[`BBF_CMD_OFS_LO +: 8];
	assign target = pc_r + {{8{ofs[7]}}, ofs} + 16'h0001;

	// One-hot mask of the selected bit.
	for (genvar i = 0; i < 8; i++) begin : g_mask
		assign mask[i] = (bsel == 3'(i));
	end

	// A write completes once address and data are both held and no response waits.
	assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
	// Data registers take software writes only while idle, so execution never races the bus.
	assign sw_wr   = wr_fire & (state_r == bbf_pkg::st_idle);

	////////////////////////////////////////////////////////////////////////////
	// AXI write channels.

	// Address and data are taken in either order and held until the write fires.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			wstrb_r       <= 4'h0;
		end else if (ce) begin
			if (wr_fire) begin
				aw_have_r     <= 1'b0;
				w_have_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_r     <= 1'b1;
					awaddr_r      <= s_axi_awaddr;
					s_axi_awready <= 1'b0;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_r     <= 1'b1;
					wdata_r      <= s_axi_wdata;
					wstrb_r      <= s_axi_wstrb;
					s_axi_wready <= 1'b0;
				end
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `BBF_RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(awaddr_r) ? `BBF_RESP_OKAY : `BBF_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI read channels.

	// One read at a time; the address is refused while the data waits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `BBF_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= mapped(s_axi_araddr) ? `BBF_RESP_OKAY : `BBF_RESP_SLVERR;
				if (hit(s_axi_araddr, `BBF_OFF_CMD)) s_axi_rdata <= cmd_r;
				else if (hit(s_axi_araddr, `BBF_OFF_FLAGS)) s_axi_rdata <= {24'h00_0000, flags_r};
				else if (hit(s_axi_araddr, `BBF_OFF_PC)) s_axi_rdata <= {16'h0000, pc_r};
				else if (hit(s_axi_araddr, `BBF_OFF_OPND)) s_axi_rdata <= {24'h00_0000, opnd_r};
				else if (hit(s_axi_araddr, `BBF_OFF_IO)) s_axi_rdata <= {24'h00_0000, io_r};
				else if (hit(s_axi_araddr, `BBF_OFF_STAT)) s_axi_rdata <= {30'h0000_0000, taken_r, busy};
				else s_axi_rdata <= 32'h0000_0000;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	// A taken branch and the IO bit operations need a second cycle; all else ends in one.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bbf_pkg::st_idle: begin
				if (sw_wr && hit(awaddr_r, `BBF_OFF_CMD)) state_nxt = bbf_pkg::st_exec;
			end
			bbf_pkg::st_exec: begin
				if ((is_branch(op) && br_cond(op, flags_r)) || op == bbf_pkg::io_bit_set ||
					op == bbf_pkg::io_bit_clear) begin
					state_nxt = bbf_pkg::st_finish;
				end else begin
					state_nxt = bbf_pkg::st_idle;
				end
			end
			bbf_pkg::st_finish: state_nxt = bbf_pkg::st_idle;
			default:            state_nxt = bbf_pkg::st_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= bbf_pkg::st_idle;
			busy    <= 1'b0;
			taken_r <= 1'b0;
			cmd_r   <= `BBF_RST_CMD;
		end else if (ce) begin
			state_r <= state_nxt;
			busy    <= (state_nxt != bbf_pkg::st_idle);
			if (sw_wr && hit(awaddr_r, `BBF_OFF_CMD)) begin
				cmd_r   <= merge(cmd_r, wdata_r, wstrb_r);
				taken_r <= 1'b0;
			end else if (state_r == bbf_pkg::st_exec && is_branch(op)) begin
				taken_r <= br_cond(op, flags_r);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Datapath: results of the current operation.

	always_comb begin
		flags_nxt = flags_r;
		opnd_nxt  = opnd_r;
		io_nxt    = io_r;
		pc_nxt    = pc_r;
		if (state_r == bbf_pkg::st_exec) begin
			case (op)
				bbf_pkg::shift_left_logical: opnd_nxt = {opnd_r[6:0], 1'b0};
				bbf_pkg::rotate_left_carry:  opnd_nxt = {opnd_r[6:0], flags_r[`BBF_FLAG_C]};
				bbf_pkg::shift_right_logical: opnd_nxt = {1'b0, opnd_r[7:1]};
				bbf_pkg::rotate_right_carry: opnd_nxt = {flags_r[`BBF_FLAG_C], opnd_r[7:1]};
				bbf_pkg::shift_right_arith:  opnd_nxt = {opnd_r[7], opnd_r[7:1]};
				bbf_pkg::nibble_swap:        opnd_nxt = {opnd_r[3:0], opnd_r[7:4]};
				bbf_pkg::flag_set_indexed:   flags_nxt[bsel] = 1'b1;
				bbf_pkg::flag_clear_indexed: flags_nxt[bsel] = 1'b0;
				bbf_pkg::bit_to_transfer_flag: flags_nxt[`BBF_FLAG_T] = |(opnd_r & mask);
				bbf_pkg::transfer_flag_to_bit:
					opnd_nxt = flags_r[`BBF_FLAG_T] ? (opnd_r | mask) : (opnd_r & ~mask);
				bbf_pkg::global_irq_on:      flags_nxt[`BBF_FLAG_I] = 1'b1;
				bbf_pkg::global_irq_off:     flags_nxt[`BBF_FLAG_I] = 1'b0;
				bbf_pkg::signed_flag_on:     flags_nxt[`BBF_FLAG_S] = 1'b1;
				bbf_pkg::signed_flag_off:    flags_nxt[`BBF_FLAG_S] = 1'b0;
				bbf_pkg::overflow_flag_on:   flags_nxt[`BBF_FLAG_V] = 1'b1;
				bbf_pkg::overflow_flag_off:  flags_nxt[`BBF_FLAG_V] = 1'b0;
				bbf_pkg::half_carry_on:      flags_nxt[`BBF_FLAG_H] = 1'b1;
				bbf_pkg::half_carry_off:     flags_nxt[`BBF_FLAG_H] = 1'b0;
				default: begin
					// An untaken branch just steps past itself; taken ones reload in finish.
					if (is_branch(op) && !br_cond(op, flags_r)) pc_nxt = pc_r + 16'h0001;
				end
			endcase
			// Shifts share one flag update: carry is the bit shifted out, V is N xor C.
			if (op >= bbf_pkg::shift_left_logical && op <= bbf_pkg::shift_right_arith) begin
				flags_nxt[`BBF_FLAG_C] = (op == bbf_pkg::shift_left_logical ||
					op == bbf_pkg::rotate_left_carry) ? opnd_r[7] : opnd_r[0];
				flags_nxt[`BBF_FLAG_Z] = (opnd_nxt == 8'h00);
				flags_nxt[`BBF_FLAG_N] = opnd_nxt[7];
				flags_nxt[`BBF_FLAG_V] = opnd_nxt[7] ^ flags_nxt[`BBF_FLAG_C];
			end
		end else if (state_r == bbf_pkg::st_finish) begin
			if (is_branch(op)) pc_nxt = target;
			if (op == bbf_pkg::io_bit_set) io_nxt = io_r | mask;
			if (op == bbf_pkg::io_bit_clear) io_nxt = io_r & ~mask;
		end
	end

	// Each architectural register takes either its result or an idle software write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= `BBF_RST_FLAGS;
			pc_r    <= `BBF_RST_PC;
			opnd_r  <= `BBF_RST_BYTE;
			io_r    <= `BBF_RST_BYTE;
		end else if (ce) begin
			flags_r <= (sw_wr && hit(awaddr_r, `BBF_OFF_FLAGS)) ?
				8'(merge({24'h00_0000, flags_r}, wdata_r, wstrb_r)) : flags_nxt;
			pc_r    <= (sw_wr && hit(awaddr_r, `BBF_OFF_PC)) ?
				16'(merge({16'h0000, pc_r}, wdata_r, wstrb_r)) : pc_nxt;
			opnd_r  <= (sw_wr && hit(awaddr_r, `BBF_OFF_OPND)) ?
				8'(merge({24'h00_0000, opnd_r}, wdata_r, wstrb_r)) : opnd_nxt;
			io_r    <= (sw_wr && hit(awaddr_r, `BBF_OFF_IO)) ?
				8'(merge({24'h00_0000, io_r}, wdata_r, wstrb_r)) : io_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks. A frozen clock enable stretches time, so the checks count enabled edges only.

	default clocking cb @(posedge aclk iff ce);
	endclocking
	default disable iff (!aresetn);

	sequence s_exec(bbf_pkg::bbf_op_t o);
		state_r == bbf_pkg::st_exec && op == o;
	endsequence

	sequence s_long;
		state_r == bbf_pkg::st_finish ##1 state_r == bbf_pkg::st_idle;
	endsequence

	a_br_carry_clear: assert property (s_exec(bbf_pkg::branch_carry_clear) |=>
		((state_r == bbf_pkg::st_finish) == !$past(flags_r[`BBF_FLAG_C])))
		else $error("carry clear branch decision wrong");
	a_br_signed_lt: assert property (s_exec(bbf_pkg::branch_signed_lt) |=>
		((state_r == bbf_pkg::st_finish) == ($past(flags_r[`BBF_FLAG_N]) ^ $past(flags_r[`BBF_FLAG_V]))))
		else $error("signed less-than branch decision wrong");
	a_br_taken_target: assert property (state_r == bbf_pkg::st_exec && is_branch(op) && br_cond(op, flags_r)
		|=> s_long ##0 (pc_r == $past(pc_r, 2) + {{8{ofs[7]}}, ofs} + 16'h0001))
		else $error("taken branch target or timing wrong");
	a_br_untaken_step: assert property (state_r == bbf_pkg::st_exec && is_branch(op) && !br_cond(op, flags_r)
		|=> state_r == bbf_pkg::st_idle && pc_r == $past(pc_r) + 16'h0001)
		else $error("untaken branch did not step in one cycle");
	a_io_bit_set: assert property (s_exec(bbf_pkg::io_bit_set) |=> s_long ##0
		(io_r[bsel] && flags_r == $past(flags_r, 2)))
		else $error("io bit set wrong");
	a_io_bit_clear: assert property (s_exec(bbf_pkg::io_bit_clear) |-> ##2 (!io_r[bsel] && busy == 1'b0))
		else $error("io bit clear wrong");
	a_rotate_left: assert property (s_exec(bbf_pkg::rotate_left_carry) |=>
		(opnd_r == {$past(opnd_r[6:0]), $past(flags_r[`BBF_FLAG_C])} && flags_r[`BBF_FLAG_C] == $past(opnd_r[7])))
		else $error("rotate left through carry wrong");
	a_shift_arith: assert property (s_exec(bbf_pkg::shift_right_arith) |=>
		(opnd_r[7:6] == {2{$past(opnd_r[7])}} && flags_r[`BBF_FLAG_C] == $past(opnd_r[0])))
		else $error("arithmetic right shift wrong");
	a_nibble_swap: assert property (s_exec(bbf_pkg::nibble_swap) |=>
		($stable(flags_r) && opnd_r == {$past(opnd_r[3:0]), $past(opnd_r[7:4])}))
		else $error("nibble swap wrong");
	a_bit_store: assert property (s_exec(bbf_pkg::bit_to_transfer_flag) |=>
		(flags_r[`BBF_FLAG_T] == $past(opnd_r[bsel]) && flags_r[5:0] == $past(flags_r[5:0])))
		else $error("bit store to transfer flag wrong");
	a_irq_on: assert property (s_exec(bbf_pkg::global_irq_on) |=>
		(flags_r[`BBF_FLAG_I] && flags_r[6:0] == $past(flags_r[6:0])))
		else $error("interrupt enable not set alone");

endmodule

`default_nettype wire

// ==== bbf_unit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bbf_consts.svh"

module bbf_unit_tb;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic [3:0]  ws = 4'hf;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        busy;
	logic        bq = 1'b0;
	logic [31:0] bcnt = 32'h0;
	int          n_fail = 0;
	int          n_checks = 0;

	bbf_unit dut_u (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.busy(busy)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Free running 50 MHz clock.
	always #10 aclk = ~aclk;

	// Length of the last busy stretch in clock cycles; restarts on each rising busy.
	always @(posedge aclk) begin
		if (busy && !bq)
			bcnt <= 32'h1;
		else if (busy)
			bcnt <= bcnt + 32'h1;
		bq <= busy;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run, shared by the main sequence and the watchdog.
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Write with address and data offered together; each is released once taken.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		@(posedge aclk);
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= ws;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				chk("bresp", {30'h0, er}, {30'h0, bresp});
				break;
			end
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm, input logic [1:0] er);
		logic ar;
		@(posedge aclk);
		ar = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (ar && arready) begin
				ar = 1'b0;
				arvalid <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				rready <= 1'b0;
				chk(nm, e, rdata);
				chk("rresp", {30'h0, er}, {30'h0, rresp});
				break;
			end
		end
	endtask

	task automatic setup(input logic [7:0] f, input logic [15:0] pc, input logic [7:0] o, input logic [7:0] io);
		axw(`BBF_OFF_FLAGS, {24'h0, f}, `BBF_RESP_OKAY);
		axw(`BBF_OFF_PC, {16'h0, pc}, `BBF_RESP_OKAY);
		axw(`BBF_OFF_OPND, {24'h0, o}, `BBF_RESP_OKAY);
		axw(`BBF_OFF_IO, {24'h0, io}, `BBF_RESP_OKAY);
	endtask

	// Start an operation, then wait a bounded time for it to finish.
	task automatic run(input logic [5:0] op, input logic [2:0] b, input logic [7:0] k);
		int t;
		axw(`BBF_OFF_CMD, {8'h00, k, 5'h00, b, 2'h0, op}, `BBF_RESP_OKAY);
		t = 0;
		while (busy !== 1'b0 && t < 20) begin
			@(posedge aclk);
			t++;
		end
		// A stuck operation counts as a mismatch rather than passing silently.
		if (busy !== 1'b0) begin
			n_fail++;
			$display("MISMATCH busy expected 0 seen %b", busy);
		end
	endtask

	task automatic result(input logic [7:0] f, input logic [15:0] pc, input logic [7:0] o, input logic [7:0] io,
		input logic [31:0] cyc);
		rdc(`BBF_OFF_FLAGS, {24'h0, f}, "flags", `BBF_RESP_OKAY);
		rdc(`BBF_OFF_PC, {16'h0, pc}, "pc", `BBF_RESP_OKAY);
		rdc(`BBF_OFF_OPND, {24'h0, o}, "operand", `BBF_RESP_OKAY);
		rdc(`BBF_OFF_IO, {24'h0, io}, "io", `BBF_RESP_OKAY);
		chk("cycles", cyc, bcnt);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Branch condition per opcode; flags are C0 Z1 N2 V3 S4 H5 T6 I7.
	function automatic logic taken(input logic [5:0] op, input logic [7:0] f);
		case (op)
			6'h00, 6'h01: return ~f[0];
			6'h02: return f[0];
			6'h03: return f[2];
			6'h04: return ~f[2];
			6'h05: return ~(f[2] ^ f[3]);
			6'h06: return f[2] ^ f[3];
			6'h07: return f[5];
			6'h08: return ~f[5];
			6'h09: return f[6];
			6'h0a: return ~f[6];
			6'h0b: return f[3];
			6'h0c: return ~f[3];
			6'h0d: return f[7];
			default: return ~f[7];
		endcase
	endfunction

	// Expected flags, operand and I/O byte after a non-branch operation.
	function automatic logic [23:0] model(input logic [5:0] op, input logic [2:0] b, input logic [7:0] f,
		input logic [7:0] o, input logic [7:0] io);
		logic [7:0] nf;
		logic [7:0] no;
		logic [7:0] ni;
		logic       c;
		nf = f;
		no = o;
		ni = io;
		c = f[0];
		case (op)
			6'h10: ni[b] = 1'b1;
			6'h11: ni[b] = 1'b0;
			6'h12: {c, no} = {o, 1'b0};
			6'h13: {no, c} = {1'b0, o};
			6'h14: {c, no} = {o, f[0]};
			6'h15: {no, c} = {f[0], o};
			6'h16: {no, c} = {o[7], o};
			6'h17: no = {o[3:0], o[7:4]};
			6'h18: nf[b] = 1'b1;
			6'h19: nf[b] = 1'b0;
			6'h1a: nf[6] = o[b];
			6'h1b: no[b] = f[6];
			6'h1c, 6'h1d: nf[7] = ~op[0];
			6'h1e, 6'h1f: nf[4] = ~op[0];
			6'h20, 6'h21: nf[3] = ~op[0];
			6'h22, 6'h23: nf[5] = ~op[0];
			default: ;
		endcase
		if (op >= 6'h12 && op <= 6'h16)
			nf[3:0] = {no[7] ^ c, no[7], no == 8'h00, c};
		return {nf, no, ni};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: far beyond the few thousand cycles the sequence needs.
	initial begin
		repeat (30000) @(posedge aclk);
		n_fail++;
		$display("MISMATCH watchdog expected done seen hang");
		final_report();
	end

	// Main sequence.
	initial begin
		logic [7:0]  fl [4];
		logic [7:0]  k;
		logic [15:0] pe;
		logic [23:0] m;
		logic        tk;
		fl = '{8'h00, 8'hff, 8'h08, 8'h04};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 6; a++)
			rdc(8'(4 * a), 32'h0, "reset value", `BBF_RESP_OKAY);
		// Unmapped place and read-only status.
		axw(8'h18, 32'hffff_ffff, `BBF_RESP_SLVERR);
		rdc(8'h18, 32'h0, "unmapped", `BBF_RESP_SLVERR);
		axw(`BBF_OFF_STAT, 32'hffff_ffff, `BBF_RESP_OKAY);
		rdc(`BBF_OFF_STAT, 32'h0, "status", `BBF_RESP_OKAY);
		// Every branch under four flag patterns, both offset signs.
		for (int fi = 0; fi < 4; fi++) begin
			for (int op = 0; op < 15; op++) begin
				k = fi[0] ? 8'hf0 : 8'h05;
				tk = taken(6'(op), fl[fi]);
				pe = tk ? 16'h0101 + {{8{k[7]}}, k} : 16'h0101;
				setup(fl[fi], 16'h0100, 8'h3c, 8'h5a);
				run(6'(op), 3'h0, k);
				result(fl[fi], pe, 8'h3c, 8'h5a, tk ? 32'h2 : 32'h1);
				rdc(`BBF_OFF_STAT, {30'h0, tk, 1'b0}, "taken", `BBF_RESP_OKAY);
			end
		end
		// Bit, shift and flag operations from two contrasting starting states.
		for (int p = 0; p < 2; p++) begin
			for (int op = 16; op < 36; op++) begin
				m = model(6'(op), p ? 3'h5 : 3'h2, p ? 8'hff : 8'h00, p ? 8'h81 : 8'h80, p ? 8'hff : 8'h00);
				setup(p ? 8'hff : 8'h00, 16'h0200, p ? 8'h81 : 8'h80, p ? 8'hff : 8'h00);
				run(6'(op), p ? 3'h5 : 3'h2, 8'h00);
				result(m[23:16], 16'h0200, m[15:8], m[7:0], (op < 18) ? 32'h2 : 32'h1);
			end
		end
		// Byte strobe: only the low byte of the counter is written.
		ws = 4'h1;
		axw(`BBF_OFF_PC, 32'h0000_abcd, `BBF_RESP_OKAY);
		ws = 4'hf;
		rdc(`BBF_OFF_PC, 32'h0000_02cd, "strobed pc", `BBF_RESP_OKAY);
		// Clock enable low for three edges after the response stretches a two-cycle op to five busy cycles.
		setup(8'h00, 16'h0300, 8'h11, 8'h00);
		fork
			run(6'h10, 3'h3, 8'h00);
			begin
				wait (busy === 1'b1);
				@(posedge aclk);
				ce <= 1'b0;
				repeat (3) @(posedge aclk);
				ce <= 1'b1;
			end
		join
		result(8'h00, 16'h0300, 8'h11, 8'h08, 32'h5);
		final_report();
	end

endmodule

`default_nettype wire
